// *** verilog/sfr_read_engine.sv ***
// Read command engine of a multi-lane serial flash, sampling the link on the core clock.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - sample inputs on rise, drive data on fall
// - address increments per byte, wraps to zero
// - opcode 03 single-lane read, no dummy
// - opcode 0B fast read, one dummy byte
// - reject reads while busy, cycle undisturbed
// - opcode 3B dual output, 8 dummy clocks
// - opcode BB dual address, 4 dummy clocks
// - opcode 6B quad output, 8 dummy clocks
// - opcode EB quad address, indicator plus dummy
// - opcode E7 quad, 4 dummy clocks total
// - opcode EB dummy count follows configuration bit
// - setting 1 gives 8, 0 gives 6
// - toggling indicator keeps continuous read mode
// - non-toggling indicator leaves continuous mode
// - continuous mode starts with quad address
// - FFh on single lane exits continuous mode
// - dual output keeps opcode, address single-lane
module sfr_read_engine
  import sfr_pkg::*;
#(
  parameter int ARRAY_AW = ARRAY_AW_DEF
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst_b,
  input  wire logic                 cs_b,
  input  wire logic                 sclk,
  input  wire logic                 io_lane0_in,
  input  wire logic                 io_lane1_in,
  input  wire logic                 io_lane2_in,
  input  wire logic                 io_lane3_in,
  output var  logic                 io_lane0_out,
  output var  logic                 io_lane1_out,
  output var  logic                 io_lane2_out,
  output var  logic                 io_lane3_out,
  output var  logic                 io_lane0_oe,
  output var  logic                 io_lane1_oe,
  output var  logic                 io_lane2_oe,
  output var  logic                 io_lane3_oe,
  input  wire logic                 write_busy,
  input  wire logic                 dummy_cycle_setting,
  input  wire logic                 mem_wr_en,
  input  wire logic [ARRAY_AW-1:0]  mem_wr_addr,
  input  wire logic [BYTE_BITS-1:0] mem_wr_data,
  output var  logic                 cont_read_mode
);

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  // Bits: 5 chip select, 4 clock, 3..0 lanes.
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic [1:0] prev_reg;
  logic [5:0] sync1_next;
  logic [5:0] sync2_next;
  logic [1:0] prev_next;

  always_comb begin
    sync1_next = {cs_b, sclk, io_lane3_in, io_lane2_in, io_lane1_in, io_lane0_in};
    sync2_next = sync1_reg;
    prev_next  = sync2_reg[5:4];
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= 6'h3F;
      sync2_reg <= 6'h3F;
      prev_reg  <= 2'h3;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      prev_reg  <= prev_next;
    end
  end

  logic       cs_s;
  logic       cs_fall;
  logic       sclk_rise;
  logic       sclk_fall;
  logic [3:0] lanes;

  // Lanes are taken from the same stage as the clock so they stay aligned.
  assign cs_s      = sync2_reg[5];
  assign cs_fall   = prev_reg[1] & ~cs_s;
  assign sclk_rise = sync2_reg[4] & ~prev_reg[0];
  assign sclk_fall = ~sync2_reg[4] & prev_reg[0];
  assign lanes     = sync2_reg[3:0];

  // ****************************************************************
  // Array
  // ****************************************************************
  logic [ADDR_BITS-1:0] addr_reg;
  logic [BYTE_BITS-1:0] mem_q;

  sfr_array #(
    .AW (ARRAY_AW)
  ) u_array (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .wr_en    (mem_wr_en),
    .wr_addr  (mem_wr_addr),
    .wr_data  (mem_wr_data),
    .rd_addr  (addr_reg[ARRAY_AW-1:0]),
    .rd_data  (mem_q)
  );

  // ****************************************************************
  // Command sequencer
  // ****************************************************************
  sfr_state_t           state_reg;
  sfr_state_t           state_next;
  sfr_mode_t            mode_reg;
  sfr_mode_t            mode_next;
  logic [CNT_W-1:0]     cnt_reg;
  logic [CNT_W-1:0]     cnt_next;
  logic [7:0]           opc_reg;
  logic [7:0]           opc_next;
  logic [ADDR_BITS-1:0] addr_next;
  logic [3:0]           ind_reg;
  logic [3:0]           ind_next;
  logic                 cont_reg;
  logic                 cont_next;
  logic [7:0]           sh_reg;
  logic [7:0]           sh_next;
  logic [2:0]           grp_reg;
  logic [2:0]           grp_next;
  logic [3:0]           out_reg;
  logic [3:0]           out_next;
  logic [3:0]           oe_reg;
  logic [3:0]           oe_next;

  always_comb begin
    logic [7:0]       opc_full;
    logic [2:0]       aw;
    logic [2:0]       dw;
    logic [CNT_W-1:0] dummy;
    logic [7:0]       word;
    opc_full   = {opc_reg[6:0], lanes[0]};
    aw         = sfr_addr_w(mode_reg);
    dw         = sfr_data_w(mode_reg);
    dummy      = sfr_dummy(mode_reg, dummy_cycle_setting);
    word       = (grp_reg == 3'h0) ? mem_q : sh_reg;
    state_next = state_reg;
    mode_next  = mode_reg;
    cnt_next   = cnt_reg;
    opc_next   = opc_reg;
    addr_next  = addr_reg;
    ind_next   = ind_reg;
    cont_next  = cont_reg;
    sh_next    = sh_reg;
    grp_next   = grp_reg;
    out_next   = out_reg;
    oe_next    = oe_reg;

    if (cs_s) begin
      // Deselect ends any read at once and releases the lanes.
      state_next = ST_IDLE;
      oe_next    = OE_OFF;
    end else if (cs_fall) begin
      cnt_next = '0;
      grp_next = '0;
      oe_next  = OE_OFF;
      if (cont_reg) begin
        // The opcode is skipped; the first clocks carry a quad address.
        state_next = write_busy ? ST_IGNORE : ST_ADDR;
      end else begin
        state_next = ST_OPCODE;
      end
    end else if (sclk_rise) begin
      case (state_reg)
        ST_OPCODE: begin
          opc_next = opc_full;
          cnt_next = cnt_reg + 1'b1;
          if (cnt_reg == CNT_W'(OPCODE_CLKS - 1)) begin
            cnt_next   = '0;
            state_next = ST_ADDR;
            if (opc_full == OP_READ) begin
              mode_next = MD_READ;
            end else if (opc_full == OP_FAST) begin
              mode_next = MD_FAST;
            end else if (opc_full == OP_DOUT) begin
              mode_next = MD_DOUT;
            end else if (opc_full == OP_DIO) begin
              mode_next = MD_DIO;
            end else if (opc_full == OP_QOUT) begin
              mode_next = MD_QOUT;
            end else if (opc_full == OP_QIO) begin
              mode_next = MD_QIO;
            end else if (opc_full == OP_QIO_ALT) begin
              mode_next = MD_QIO_ALT;
            end else begin
              state_next = ST_IGNORE;
              if (opc_full == OP_ENH_RESET) begin
                cont_next = 1'b0;
              end
            end
            // A busy array refuses the read and leaves the write cycle alone.
            if (write_busy) begin
              state_next = ST_IGNORE;
            end
          end
        end
        ST_ADDR: begin
          case (aw)
            W2:      addr_next = {addr_reg[ADDR_BITS-3:0], lanes[1:0]};
            W4:      addr_next = {addr_reg[ADDR_BITS-5:0], lanes};
            default: addr_next = {addr_reg[ADDR_BITS-2:0], lanes[0]};
          endcase
          cnt_next = cnt_reg + 1'b1;
          if (cnt_reg == sfr_clks(ADDR_BITS, aw) - 1'b1) begin
            cnt_next   = '0;
            state_next = (dummy == '0) ? ST_DATA : ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          cnt_next = cnt_reg + 1'b1;
          if (mode_reg == MD_QIO || mode_reg == MD_QIO_ALT) begin
            if (cnt_reg == IND_FIRST) begin
              ind_next = lanes;
            end else if (cnt_reg == IND_SECOND) begin
              // FFh sent in continuous mode lands here too: lane 0 high on both
              // indicator clocks never toggles, so the mode is left.
              cont_next = (ind_reg == ~lanes);
            end
          end
          if (cnt_reg == dummy - 1'b1) begin
            cnt_next   = '0;
            state_next = ST_DATA;
          end
        end
        default: begin
        end
      endcase
    end else if (sclk_fall && state_reg == ST_DATA) begin
      case (dw)
        W2: begin
          out_next = {2'b00, word[7:6]};
          oe_next  = OE_W2;
        end
        W4: begin
          out_next = word[7:4];
          oe_next  = OE_W4;
        end
        default: begin
          out_next = {2'b00, word[7], 1'b0};
          oe_next  = OE_W1;
        end
      endcase
      sh_next  = 8'(word << dw);
      grp_next = grp_reg + 1'b1;
      if ({2'b00, grp_reg} == sfr_clks(BYTE_BITS, dw) - 1'b1) begin
        grp_next = '0;
        // Only the low array bits count, so the top address rolls to zero.
        addr_next = ADDR_BITS'(ARRAY_AW'(addr_reg[ARRAY_AW-1:0] + 1'b1));
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      mode_reg  <= MD_READ;
      cnt_reg   <= '0;
      opc_reg   <= '0;
      addr_reg  <= '0;
      ind_reg   <= '0;
      cont_reg  <= 1'b0;
      sh_reg    <= '0;
      grp_reg   <= '0;
      out_reg   <= '0;
      oe_reg    <= OE_OFF;
    end else begin
      state_reg <= state_next;
      mode_reg  <= mode_next;
      cnt_reg   <= cnt_next;
      opc_reg   <= opc_next;
      addr_reg  <= addr_next;
      ind_reg   <= ind_next;
      cont_reg  <= cont_next;
      sh_reg    <= sh_next;
      grp_reg   <= grp_next;
      out_reg   <= out_next;
      oe_reg    <= oe_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign io_lane0_out   = out_reg[0];
  assign io_lane1_out   = out_reg[1];
  assign io_lane2_out   = out_reg[2];
  assign io_lane3_out   = out_reg[3];
  assign io_lane0_oe    = oe_reg[0];
  assign io_lane1_oe    = oe_reg[1];
  assign io_lane2_oe    = oe_reg[2];
  assign io_lane3_oe    = oe_reg[3];
  assign cont_read_mode = cont_reg;

endmodule // sfr_read_engine
`default_nettype wire

// *** verilog/sfr_pkg.sv ***
// Shared constants, types and decode functions of the serial flash read engine.
package sfr_pkg;

  // ****************************************************************
  // Instruction codes
  // ****************************************************************
  localparam logic [7:0] OP_READ      = 8'h03;
  localparam logic [7:0] OP_FAST      = 8'h0B;
  localparam logic [7:0] OP_DOUT      = 8'h3B;
  localparam logic [7:0] OP_DIO       = 8'hBB;
  localparam logic [7:0] OP_QOUT      = 8'h6B;
  localparam logic [7:0] OP_QIO       = 8'hEB;
  localparam logic [7:0] OP_QIO_ALT   = 8'hE7;
  localparam logic [7:0] OP_ENH_RESET = 8'hFF;

  // ****************************************************************
  // Sizes and clock counts
  // ****************************************************************
  localparam int ADDR_BITS    = 24;
  localparam int ARRAY_AW_DEF = 23;
  localparam int BYTE_BITS    = 8;
  localparam int CNT_W        = 5;
  localparam int OPCODE_CLKS  = 8;
  localparam int DUMMY_NONE   = 0;
  localparam int DUMMY_FAST   = 8;
  localparam int DUMMY_DOUT   = 8;
  localparam int DUMMY_QOUT   = 8;
  localparam int DUMMY_DIO    = 4;
  localparam int DUMMY_QIO_DC1 = 8;
  localparam int DUMMY_QIO_DC0 = 6;
  localparam int DUMMY_QIO_ALT = 4;
  localparam logic [CNT_W-1:0] IND_FIRST  = 5'h00;
  localparam logic [CNT_W-1:0] IND_SECOND = 5'h01;

  // Lane widths and the lanes they enable on output.
  localparam logic [2:0] W1 = 3'h1;
  localparam logic [2:0] W2 = 3'h2;
  localparam logic [2:0] W4 = 3'h4;
  localparam logic [3:0] OE_W1 = 4'h2;
  localparam logic [3:0] OE_W2 = 4'h3;
  localparam logic [3:0] OE_W4 = 4'hF;
  localparam logic [3:0] OE_OFF = 4'h0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    MD_READ, MD_FAST, MD_DOUT, MD_DIO, MD_QOUT, MD_QIO, MD_QIO_ALT
  } sfr_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_OPCODE, ST_ADDR, ST_DUMMY, ST_DATA, ST_IGNORE
  } sfr_state_t;

  // ****************************************************************
  // Decode functions
  // ****************************************************************
  function automatic logic [2:0] sfr_addr_w(input sfr_mode_t m);
    case (m)
      MD_DIO:                    sfr_addr_w = W2;
      MD_QIO, MD_QIO_ALT:        sfr_addr_w = W4;
      default:                   sfr_addr_w = W1;
    endcase
  endfunction

  function automatic logic [2:0] sfr_data_w(input sfr_mode_t m);
    case (m)
      MD_DOUT, MD_DIO:                   sfr_data_w = W2;
      MD_QOUT, MD_QIO, MD_QIO_ALT:       sfr_data_w = W4;
      default:                           sfr_data_w = W1;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] sfr_dummy(input sfr_mode_t m, input logic dc);
    int n;
    case (m)
      MD_FAST:    n = DUMMY_FAST;
      MD_DOUT:    n = DUMMY_DOUT;
      MD_QOUT:    n = DUMMY_QOUT;
      MD_DIO:     n = DUMMY_DIO;
      MD_QIO:     n = dc ? DUMMY_QIO_DC1 : DUMMY_QIO_DC0;
      MD_QIO_ALT: n = DUMMY_QIO_ALT;
      default:    n = DUMMY_NONE;
    endcase
    sfr_dummy = CNT_W'(n);
  endfunction

  // Clocks per byte, or per address, at a given lane width.
  function automatic logic [CNT_W-1:0] sfr_clks(input int bits, input logic [2:0] w);
    sfr_clks = CNT_W'(bits / int'(w));
  endfunction

endpackage : sfr_pkg

// *** verilog/sfr_array.sv ***
// Byte-wide memory array with a load port and a registered read port.
`timescale 1ns/100ps
`default_nettype none
module sfr_array
  import sfr_pkg::*;
#(
  parameter int AW = ARRAY_AW_DEF
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst_b,
  input  wire logic                 wr_en,
  input  wire logic [AW-1:0]        wr_addr,
  input  wire logic [BYTE_BITS-1:0] wr_data,
  input  wire logic [AW-1:0]        rd_addr,
  output var  logic [BYTE_BITS-1:0] rd_data
);

  logic [BYTE_BITS-1:0] mem [0:(1<<AW)-1];
  logic [BYTE_BITS-1:0] rd_data_next;

  always_comb begin
    rd_data_next = mem[rd_addr];
  end

  // The array content carries no reset; only the read register does.
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= '0;
    end else begin
      rd_data <= rd_data_next;
    end
  end

endmodule // sfr_array
`default_nettype wire

// *** testbench/sfr_read_engine_checker.sv ***
// Pin-level assertions for the serial flash read engine.
`timescale 1ns/100ps
`default_nettype none
module sfr_read_engine_checker (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic sclk,
  input wire logic write_busy,
  input wire logic cont_read_mode,
  input wire logic io_lane0_out,
  input wire logic io_lane1_out,
  input wire logic io_lane2_out,
  input wire logic io_lane3_out,
  input wire logic io_lane0_oe,
  input wire logic io_lane1_oe,
  input wire logic io_lane2_oe,
  input wire logic io_lane3_oe
);
  logic [3:0] oe;
  logic [3:0] drv;
  logic       busy_frame_reg;
  logic       busy_frame_next;

  assign oe  = {io_lane3_oe, io_lane2_oe, io_lane1_oe, io_lane0_oe};
  assign drv = oe & {io_lane3_out, io_lane2_out, io_lane1_out, io_lane0_out};

  // Remembers a frame that has seen busy from its very start.
  always_comb begin
    busy_frame_next = cs_b ? write_busy : (busy_frame_reg & write_busy);
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_frame_reg <= 1'b0;
    end else begin
      busy_frame_reg <= busy_frame_next;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_cs_idle;
    cs_b [*5];
  endsequence
  sequence s_oe_drop;
    $fell(io_lane1_oe);
  endsequence

  a_idle_released: assert property (s_cs_idle |-> oe == 4'h0)
    else $error("lanes driven while deselected");
  a_oe_shape: assert property (oe inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("illegal lane enable pattern");
  a_busy_silent: assert property ((!cs_b && busy_frame_reg) |-> oe == 4'h0)
    else $error("read served while busy");
  a_cont_in_frame: assert property ($changed(cont_read_mode) |-> !cs_b)
    else $error("continuous mode moved outside a frame");
  a_data_on_fall: assert property (($changed(drv) && oe != 4'h0 && $past(oe) != 4'h0)
    |-> !$past(sclk, 3))
    else $error("data changed away from a falling clock");
  a_oe_start_fall: assert property ($rose(io_lane1_oe) |-> !$past(sclk, 3) && !cs_b)
    else $error("data phase started off a falling clock");
  a_oe_end_cs: assert property (s_oe_drop |-> $past(cs_b, 2))
    else $error("output released without deselect");
  a_oe_drop_bound: assert property ($rose(cs_b) |-> ##[1:5] (oe == 4'h0))
    else $error("output not released after deselect");
endmodule  // sfr_read_engine_checker

bind sfr_read_engine sfr_read_engine_checker u_chk (.core_clk, .rst_b, .cs_b, .sclk,
  .write_busy, .cont_read_mode, .io_lane0_out, .io_lane1_out, .io_lane2_out,
  .io_lane3_out, .io_lane0_oe, .io_lane1_oe, .io_lane2_oe, .io_lane3_oe);
`default_nettype wire

// *** testbench/sfr_host_model.sv ***
// Host controller model that frames reads on the serial link.
`timescale 1ns/100ps
`default_nettype none
module sfr_host_model (
  output var  logic       cs_b,
  output var  logic       sclk,
  output var  logic [3:0] host_val,
  output var  logic [3:0] host_oe,
  input  wire logic [3:0] lane
);
  localparam time HALF = 16;

  initial begin
    cs_b = 1'b1;
    sclk = 1'b0;
    host_val = 4'h0;
    host_oe = 4'h0;
  end

  // One link clock driving w lanes (none when 0); r takes the lanes at the rise.
  task automatic tick(input logic [3:0] v, input int w, output logic [3:0] r);
    host_oe = (w == 4) ? 4'hF : (w == 2) ? 4'h3 : (w == 1) ? 4'h1 : 4'h0;
    host_val = v;
    #HALF sclk = 1'b1;
    r = lane;
    #HALF sclk = 1'b0;
  endtask

  task automatic frame(input logic [7:0] op, input bit cont, input logic [23:0] a,
                       input int aw, input int nd, input logic [7:0] ind,
                       input int dw, output logic [7:0] q[4]);
    logic [3:0]  r;
    logic [31:0] sh;
    sh = 32'h0000_0000;
    cs_b = 1'b0;
    #HALF;
    for (int i = 7; i >= 0 && !cont; i--) tick({3'h0, op[i]}, 1, r);
    for (int i = 24 - aw; i >= 0; i -= aw) tick(4'((a >> i) & ((1 << aw) - 1)), aw, r);
    for (int i = 0; i < nd; i++) tick(i == 0 ? ind[7:4] : ind[3:0],
                                      (i < 2 && aw > 1) ? aw : 0, r);
    for (int b = 0; b < 32 / dw; b++) begin
      tick(4'h0, 0, r);
      sh = (sh << dw) | ((dw == 1) ? r[1] : (dw == 2) ? r[1:0] : r);
    end
    for (int k = 0; k < 4; k++) q[k] = sh[8 * (3 - k) +: 8];
    cs_b = 1'b1;
    #(HALF * 2);
  endtask

  task automatic ffexit;
    logic [3:0] r;
    cs_b = 1'b0;
    #HALF;
    for (int i = 0; i < 8; i++) tick(4'h1, 1, r);
    cs_b = 1'b1;
    #(HALF * 2);
  endtask
endmodule  // sfr_host_model
`default_nettype wire

// *** testbench/test_sfr_read_engine.sv ***
// Self-checking bench for the serial flash read engine.
`timescale 1ns/100ps
`default_nettype none
module test_sfr_read_engine import sfr_pkg::*;;
  localparam int AW = 8;
  localparam logic [7:0] OPS [7] = '{OP_READ, OP_FAST, OP_DOUT, OP_DIO, OP_QOUT, OP_QIO,
                                     OP_QIO_ALT};
  logic            core_clk;
  logic            rst_b;
  logic            write_busy;
  logic            dummy_cycle_setting;
  logic            mem_wr_en;
  logic [AW-1:0]   mem_wr_addr;
  logic [7:0]      mem_wr_data;
  logic [7:0]      mem [256];
  logic [7:0]      q [4];
  logic            cs_b;
  logic            sclk;
  logic            cont_read_mode;
  logic [3:0]      host_val;
  logic [3:0]      host_oe;
  logic [3:0]      flt;
  wire logic [3:0] lane;
  wire logic [3:0] dev_out;
  wire logic [3:0] dev_oe;
  int              fails;
  int              comparisons;
  bit              seen_oe;

  // A lane nobody drives flips every cycle so stale data cannot pass.
  assign lane = (dev_oe & dev_out) | (~dev_oe & host_oe & host_val) | (~dev_oe & ~host_oe & flt);

  sfr_host_model host (.cs_b(cs_b), .sclk(sclk), .host_val(host_val), .host_oe(host_oe),
                       .lane(lane));

  sfr_read_engine #(.ARRAY_AW(AW)) uut (
    .core_clk(core_clk), .rst_b(rst_b), .cs_b(cs_b), .sclk(sclk),
    .io_lane0_in(lane[0]), .io_lane1_in(lane[1]), .io_lane2_in(lane[2]),
    .io_lane3_in(lane[3]), .io_lane0_out(dev_out[0]), .io_lane1_out(dev_out[1]),
    .io_lane2_out(dev_out[2]), .io_lane3_out(dev_out[3]), .io_lane0_oe(dev_oe[0]),
    .io_lane1_oe(dev_oe[1]), .io_lane2_oe(dev_oe[2]), .io_lane3_oe(dev_oe[3]),
    .write_busy(write_busy), .dummy_cycle_setting(dummy_cycle_setting),
    .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .cont_read_mode(cont_read_mode));

  always @(posedge core_clk) begin
    flt <= ~flt;
    if (dev_oe !== 4'h0) seen_oe <= 1'b1;
  end

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // ****************************************************************
  // Compare, frame and closing tasks
  // ****************************************************************
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t data %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t flag %b expected %b", $time, g, e);
    end
  endtask

  task automatic rd(input logic [7:0] op, input bit cont, input logic [7:0] a,
                    input logic [7:0] ind);
    logic [11:0] cfg;
    cfg = {4'h1, 4'h8, 4'h1};
    case (op)
      OP_READ:    cfg = {4'h1, 4'h0, 4'h1};
      OP_DOUT:    cfg = {4'h1, 4'h8, 4'h2};
      OP_DIO:     cfg = {4'h2, 4'h4, 4'h2};
      OP_QOUT:    cfg = {4'h1, 4'h8, 4'h4};
      OP_QIO:     cfg = {4'h4, dummy_cycle_setting ? 4'h8 : 4'h6, 4'h4};
      OP_QIO_ALT: cfg = {4'h4, 4'h4, 4'h4};
      default:    ;
    endcase
    seen_oe = 1'b0;
    host.frame(op, cont, {16'h0000, a}, int'(cfg[11:8]), int'(cfg[7:4]), ind,
               int'(cfg[3:0]), q);
    if (write_busy) chk1(seen_oe, 1'b0);
    else for (int k = 0; k < 4; k++) chk8(q[k], mem[a + 8'(k)]);
  endtask

  task automatic end_sim;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #400_000;
    fails++;
    $display("BAD %0t timeout", $time);
    end_sim;
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst_b = 1'b0;
    write_busy = 1'b0;
    dummy_cycle_setting = 1'b0;
    mem_wr_en = 1'b0;
    mem_wr_addr = '0;
    mem_wr_data = 8'h00;
    flt = 4'h5;
    fails = 0;
    comparisons = 0;
    void'($urandom(32'hef77_8cdc));
    repeat (4) @(posedge core_clk);
    #1 rst_b = 1'b1;
    for (int i = 0; i < 256; i++) begin
      @(posedge core_clk);
      #1 mem_wr_en = 1'b1;
      mem_wr_addr = AW'(i);
      mem_wr_data = 8'($urandom);
      mem[i] = mem_wr_data;
    end
    @(posedge core_clk);
    #1 mem_wr_en = 1'b0;
    for (int d = 0; d < 2; d++) begin
      dummy_cycle_setting = d[0];
      foreach (OPS[j]) rd(OPS[j], 1'b0, 8'($urandom), 8'h00);
      rd(OPS[$urandom_range(6)], 1'b0, 8'hFE, 8'hFF);
      rd(OP_QIO, 1'b0, 8'hFD, 8'hFF);
    end
    rd(OP_QIO, 1'b0, 8'($urandom), 8'hA5);
    chk1(cont_read_mode, 1'b1);
    rd(OP_QIO, 1'b1, 8'($urandom), 8'h5A);
    chk1(cont_read_mode, 1'b1);
    rd(OP_QIO, 1'b1, 8'($urandom), 8'hAA);
    chk1(cont_read_mode, 1'b0);
    rd(OP_READ, 1'b0, 8'($urandom), 8'h00);
    rd(OP_QIO_ALT, 1'b0, 8'($urandom), 8'h0F);
    chk1(cont_read_mode, 1'b1);
    host.ffexit;
    chk1(cont_read_mode, 1'b0);
    rd(OP_FAST, 1'b0, 8'($urandom), 8'h00);
    write_busy = 1'b1;
    // Busy must be seen before select falls, or the checker misses the first frame.
    repeat (2) @(posedge core_clk);
    #1;
    foreach (OPS[j]) rd(OPS[j], 1'b0, 8'($urandom), 8'h00);
    write_busy = 1'b0;
    rd(OP_READ, 1'b0, 8'($urandom), 8'h00);
    end_sim;
  end
endmodule  // test_sfr_read_engine
`default_nettype wire
